//--- verilog/mlo_core.sv
/*
 * Execution unit for literal, move, logic and rotate instructions,
 * with its accumulator, flags, file registers, program counter and
 * return stack, all reachable from APB.
 * Assumes a single pclk domain and an APB master; an instruction
 * executes in the access cycle of its APB write.
 */
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
module mlo_core (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt enable state for the core
    output logic             global_irq_enable
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [mlo_pkg::DW-1:0]  file_mem [2**mlo_pkg::FAW];
    logic [mlo_pkg::PCW-1:0] stack_mem [mlo_pkg::STACK_DEPTH];

    logic [mlo_pkg::DW-1:0]  acc_q, acc_d;
    logic                    zero_q, zero_d;
    logic                    carry_q, carry_d;
    logic                    gie_q, gie_d;
    logic                    ill_q, ill_d;
    logic [mlo_pkg::PCW-1:0] pc_q, pc_d;
    logic [mlo_pkg::SPW-1:0] sp_q, sp_d;
    logic [mlo_pkg::FAW-1:0] faddr_q, faddr_d;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic                    acc_phase;
    logic                    wr_en;
    logic                    mapped;
    logic                    exec;
    logic [mlo_pkg::IW-1:0]  instr;
    logic [mlo_pkg::FAW-1:0] op_faddr;
    logic [mlo_pkg::DW-1:0]  fval;
    logic [mlo_pkg::DW-1:0]  k_lit;
    logic [mlo_pkg::PCW-1:0] stack_top_entry;

    // Byte lanes: a write needs the lanes that hold the field
    function automatic logic lane_ok(input logic [3:0] strb, input int bits);
        lane_ok = (bits <= 8) ? strb[0] : (strb[1] & strb[0]);
    endfunction : lane_ok

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    assign acc_phase = psel & penable;
    assign wr_en = acc_phase & pwrite;
    assign mapped = hit(paddr, mlo_pkg::ADDR_INSTR) | hit(paddr, mlo_pkg::ADDR_ACC)
                  | hit(paddr, mlo_pkg::ADDR_STATUS) | hit(paddr, mlo_pkg::ADDR_PC)
                  | hit(paddr, mlo_pkg::ADDR_FADDR) | hit(paddr, mlo_pkg::ADDR_FDATA)
                  | hit(paddr, mlo_pkg::ADDR_STACK);
    assign pready = 1'b1;
    assign pslverr = acc_phase & ~mapped;

    assign exec = wr_en & hit(paddr, mlo_pkg::ADDR_INSTR) & lane_ok(pstrb, mlo_pkg::IW);
    assign instr = pwdata[mlo_pkg::IW-1:0];
    assign k_lit = instr[mlo_pkg::LIT_MSB:0];
    assign op_faddr = instr[mlo_pkg::FADR_MSB:0];
    assign fval = file_mem[op_faddr];
    assign stack_top_entry = stack_mem[sp_q == mlo_pkg::SP_RST ? mlo_pkg::SP_RST[2:0] : 3'(sp_q - 4'h1)];

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    logic [mlo_pkg::DW-1:0] result;
    logic                   wr_acc, wr_file, upd_zero, upd_carry;
    logic                   carry_out, pop, illegal;

    mlo_alu u_alu (
        .instr     (instr),
        .acc       (acc_q),
        .fval      (fval),
        .carry     (carry_q),
        .result    (result),
        .wr_acc    (wr_acc),
        .wr_file   (wr_file),
        .upd_zero  (upd_zero),
        .upd_carry (upd_carry),
        .carry_out (carry_out),
        .pop       (pop),
        .illegal   (illegal)
    );

    // ----------------------------------------
    // Architectural state
    // ----------------------------------------
    always_comb begin
        acc_d = acc_q;
        zero_d = zero_q;
        carry_d = carry_q;
        gie_d = gie_q;
        ill_d = ill_q;
        pc_d = pc_q;
        sp_d = sp_q;
        faddr_d = faddr_q;
        if (exec) begin
            if (wr_acc) begin
                acc_d = result;
            end
            if (upd_zero) begin
                zero_d = (result == '0);
            end
            if (upd_carry) begin
                carry_d = carry_out;
            end
            if (illegal) begin
                ill_d = 1'b1;
            end
            if (pop) begin
                pc_d = stack_top_entry;
                gie_d = 1'b1;
                if (sp_q != mlo_pkg::SP_RST) begin
                    sp_d = sp_q - 4'h1;
                end
            end else begin
                pc_d = pc_q + 13'h0001;
            end
        end else if (wr_en) begin
            if (hit(paddr, mlo_pkg::ADDR_ACC) && pstrb[0]) begin
                acc_d = pwdata[mlo_pkg::DW-1:0];
            end
            if (hit(paddr, mlo_pkg::ADDR_STATUS) && pstrb[0]) begin
                zero_d = pwdata[mlo_pkg::ST_ZERO];
                carry_d = pwdata[mlo_pkg::ST_CARRY];
                gie_d = pwdata[mlo_pkg::ST_GIE];
                // Write one to clear the illegal flag
                ill_d = ill_q & ~pwdata[mlo_pkg::ST_ILLEGAL];
            end
            if (hit(paddr, mlo_pkg::ADDR_FADDR) && pstrb[0]) begin
                faddr_d = pwdata[mlo_pkg::FAW-1:0];
            end
            // A full stack ignores further pushes
            if (hit(paddr, mlo_pkg::ADDR_STACK) && lane_ok(pstrb, mlo_pkg::PCW)
                && sp_q != 4'(mlo_pkg::STACK_DEPTH)) begin
                sp_d = sp_q + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= mlo_pkg::ACC_RST;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
            gie_q <= 1'b0;
            ill_q <= 1'b0;
            pc_q <= mlo_pkg::PC_RST;
            sp_q <= mlo_pkg::SP_RST;
            faddr_q <= mlo_pkg::FADDR_RST;
        end else begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            gie_q <= gie_d;
            ill_q <= ill_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            faddr_q <= faddr_d;
        end
    end

    // ----------------------------------------
    // Memories
    // ----------------------------------------
    // No reset on the arrays: contents are undefined until written
    always_ff @(posedge pclk) begin
        if (exec && wr_file) begin
            file_mem[op_faddr] <= result;
        end else if (wr_en && hit(paddr, mlo_pkg::ADDR_FDATA) && pstrb[0]) begin
            file_mem[faddr_q] <= pwdata[mlo_pkg::DW-1:0];
        end
        if (wr_en && !exec && hit(paddr, mlo_pkg::ADDR_STACK) && lane_ok(pstrb, mlo_pkg::PCW)
            && sp_q != 4'(mlo_pkg::STACK_DEPTH)) begin
            stack_mem[sp_q[2:0]] <= pwdata[mlo_pkg::PCW-1:0];
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            unique case (1'b1)
                hit(paddr, mlo_pkg::ADDR_ACC): rdata_d[mlo_pkg::DW-1:0] = acc_q;
                hit(paddr, mlo_pkg::ADDR_STATUS): begin
                    rdata_d[mlo_pkg::ST_ZERO] = zero_q;
                    rdata_d[mlo_pkg::ST_CARRY] = carry_q;
                    rdata_d[mlo_pkg::ST_GIE] = gie_q;
                    rdata_d[mlo_pkg::ST_ILLEGAL] = ill_q;
                end
                hit(paddr, mlo_pkg::ADDR_PC): rdata_d[mlo_pkg::PCW-1:0] = pc_q;
                hit(paddr, mlo_pkg::ADDR_FADDR): rdata_d[mlo_pkg::FAW-1:0] = faddr_q;
                hit(paddr, mlo_pkg::ADDR_FDATA): rdata_d[mlo_pkg::DW-1:0] = file_mem[faddr_q];
                hit(paddr, mlo_pkg::ADDR_STACK): rdata_d[mlo_pkg::SPW-1:0] = sp_q;
                default: rdata_d = 32'h00000000;
            endcase
        end else if (acc_phase) begin
            // Hold through the access phase
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
    assign global_irq_enable = gie_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    function automatic logic is_op(input logic [mlo_pkg::IW-1:0] i, input mlo_pkg::mlo_op_e o);
        is_op = (i[mlo_pkg::OP_MSB:mlo_pkg::OP_LSB] == o);
    endfunction : is_op

    logic d_bit;
    assign d_bit = instr[mlo_pkg::DEST_BIT];

    AST_OR_IMM: assert property (exec && is_op(instr, mlo_pkg::OP_OR_IMM) |=>
        acc_q == ($past(acc_q) | $past(k_lit)) && zero_q == (acc_q == 8'h00))
        else $error("OR immediate result or zero flag wrong");

    AST_LOAD_IMM: assert property (exec && is_op(instr, mlo_pkg::OP_LOAD_IMM) |=>
        acc_q == $past(k_lit) && $stable(zero_q) && $stable(carry_q))
        else $error("Load immediate wrong or flags changed");

    AST_OR_FILE: assert property (exec && is_op(instr, mlo_pkg::OP_OR_FILE) && !d_bit |=>
        acc_q == ($past(acc_q) | $past(fval)) && zero_q == (acc_q == 8'h00))
        else $error("OR with file result or zero flag wrong");

    AST_DEST_FILE: assert property (exec && is_op(instr, mlo_pkg::OP_OR_FILE) && d_bit |=>
        $stable(acc_q) && file_mem[$past(op_faddr)] == ($past(acc_q) | $past(fval)))
        else $error("Destination select one did not write file");

    AST_STORE: assert property (exec && is_op(instr, mlo_pkg::OP_STORE) |=>
        file_mem[$past(op_faddr)] == $past(acc_q) && $stable(zero_q) && $stable(carry_q))
        else $error("Store accumulator wrong or flags changed");

    AST_COPY_Z: assert property (exec && is_op(instr, mlo_pkg::OP_COPY) |=>
        zero_q == ($past(fval) == 8'h00))
        else $error("Copy file did not update zero flag");

    AST_ROT: assert property (exec && is_op(instr, mlo_pkg::OP_ROT_LEFT) && !d_bit |=>
        carry_q == $past(fval[7]) && acc_q == {$past(fval[6:0]), $past(carry_q)} && $stable(zero_q))
        else $error("Rotate left through carry wrong");

    AST_RET_IRQ: assert property (exec && is_op(instr, mlo_pkg::OP_RET_IRQ) |=>
        pc_q == $past(stack_top_entry) && gie_q && $stable(zero_q) && $stable(carry_q))
        else $error("Interrupt return did not restore state");

    AST_IDLE: assert property (exec && is_op(instr, mlo_pkg::OP_IDLE) |=>
        pc_q == 13'($past(pc_q) + 13'h0001) && $stable(acc_q) && $stable(zero_q) && $stable(carry_q))
        else $error("Idle instruction changed state");

    AST_COPY_ACC: assert property (exec && is_op(instr, mlo_pkg::OP_COPY) && !d_bit |=>
        acc_q == $past(fval) && $stable(carry_q))
        else $error("Copy file to accumulator wrong");

    AST_ROT_FILE: assert property (exec && is_op(instr, mlo_pkg::OP_ROT_LEFT) && d_bit |=>
        file_mem[$past(op_faddr)] == {$past(fval[6:0]), $past(carry_q)} && $stable(acc_q))
        else $error("Rotate left into file wrong");

    AST_STORE_KEEP: assert property (exec && is_op(instr, mlo_pkg::OP_STORE) |=>
        $stable(acc_q) && $stable(gie_q) && pc_q == 13'($past(pc_q) + 13'h0001))
        else $error("Store accumulator changed other state");

    AST_ILLEGAL: assert property (exec && instr[mlo_pkg::OP_MSB] |=>
        ill_q && $stable(acc_q) && pc_q == 13'($past(pc_q) + 13'h0001))
        else $error("Illegal code did not act as idle");

    COV_OR_ZERO: cover property (exec && is_op(instr, mlo_pkg::OP_OR_IMM) ##1 zero_q);
    COV_ROT_FILE: cover property (exec && is_op(instr, mlo_pkg::OP_ROT_LEFT) && d_bit);
    COV_RET_IRQ: cover property (exec && is_op(instr, mlo_pkg::OP_RET_IRQ) && sp_q != 4'h0);
    COV_COPY_FILE: cover property (exec && is_op(instr, mlo_pkg::OP_COPY) && d_bit);
    COV_ILLEGAL: cover property (exec && instr[mlo_pkg::OP_MSB]);

endmodule : mlo_core

//--- pkg/mlo_pkg.sv
/*
 * Constants, opcode encoding and register map of the literal, move
 * and logic execution unit.
 * Assumes an APB master on pclk and a 14-bit instruction word
 * written by software, one instruction per write.
 */
package mlo_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DW = 8;
    localparam int FAW = 7;
    localparam int PCW = 13;
    localparam int IW = 14;
    localparam int STACK_DEPTH = 8;
    localparam int SPW = 4;

    // ----------------------------------------
    // Instruction fields
    // ----------------------------------------
    localparam int OP_MSB = 13;
    localparam int OP_LSB = 10;
    localparam int DEST_BIT = 7;
    localparam int LIT_MSB = 7;
    localparam int FADR_MSB = 6;

    typedef enum logic [3:0] {
        OP_IDLE     = 4'h0,
        OP_OR_IMM   = 4'h1,
        OP_LOAD_IMM = 4'h2,
        OP_OR_FILE  = 4'h3,
        OP_STORE    = 4'h4,
        OP_COPY     = 4'h5,
        OP_RET_IRQ  = 4'h6,
        OP_ROT_LEFT = 4'h7
    } mlo_op_e;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PC = 8'h0C;
    localparam logic [7:0] ADDR_FADDR = 8'h10;
    localparam logic [7:0] ADDR_FDATA = 8'h14;
    localparam logic [7:0] ADDR_STACK = 8'h18;

    // Status bit positions
    localparam int ST_ZERO = 0;
    localparam int ST_CARRY = 1;
    localparam int ST_GIE = 2;
    localparam int ST_ILLEGAL = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [DW-1:0] ACC_RST = 8'h00;
    localparam logic [PCW-1:0] PC_RST = 13'h0000;
    localparam logic [FAW-1:0] FADDR_RST = 7'h00;
    localparam logic [SPW-1:0] SP_RST = 4'h0;

endpackage : mlo_pkg

//--- verilog/mlo_alu.sv
/*
 * Combinational result and flag logic for one instruction.
 * Assumes operands are already read: accumulator, addressed file
 * register value and current carry.
 */
`timescale 1ns/1ps
module mlo_alu (
    // Instruction
    input  wire logic [mlo_pkg::IW-1:0] instr,
    // Operands
    input  wire logic [mlo_pkg::DW-1:0] acc,
    input  wire logic [mlo_pkg::DW-1:0] fval,
    input  wire logic                   carry,
    // Results
    output logic      [mlo_pkg::DW-1:0] result,
    output logic                        wr_acc,
    output logic                        wr_file,
    output logic                        upd_zero,
    output logic                        upd_carry,
    output logic                        carry_out,
    output logic                        pop,
    output logic                        illegal
);
    logic [mlo_pkg::DW-1:0] lit;
    logic                   dest;

    assign lit = instr[mlo_pkg::LIT_MSB:0];
    assign dest = instr[mlo_pkg::DEST_BIT];

    always_comb begin
        result = acc;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_zero = 1'b0;
        upd_carry = 1'b0;
        carry_out = carry;
        pop = 1'b0;
        illegal = 1'b0;
        unique case (instr[mlo_pkg::OP_MSB:mlo_pkg::OP_LSB])
            mlo_pkg::OP_IDLE: begin
                result = acc;
            end
            mlo_pkg::OP_OR_IMM: begin
                result = acc | lit;
                wr_acc = 1'b1;
                upd_zero = 1'b1;
            end
            mlo_pkg::OP_LOAD_IMM: begin
                result = lit;
                wr_acc = 1'b1;
            end
            mlo_pkg::OP_OR_FILE: begin
                result = acc | fval;
                wr_acc = ~dest;
                wr_file = dest;
                upd_zero = 1'b1;
            end
            mlo_pkg::OP_STORE: begin
                result = acc;
                wr_file = 1'b1;
            end
            mlo_pkg::OP_COPY: begin
                result = fval;
                wr_acc = ~dest;
                wr_file = dest;
                upd_zero = 1'b1;
            end
            mlo_pkg::OP_RET_IRQ: begin
                pop = 1'b1;
            end
            mlo_pkg::OP_ROT_LEFT: begin
                result = {fval[mlo_pkg::DW-2:0], carry};
                carry_out = fval[mlo_pkg::DW-1];
                upd_carry = 1'b1;
                wr_acc = ~dest;
                wr_file = dest;
            end
            default: begin
                // Unknown codes behave as idle and raise a sticky flag
                illegal = 1'b1;
            end
        endcase
    end

endmodule : mlo_alu

//--- tb/mlo_apb_master.sv
/*
 * APB master standing in for instruction fetch and decode: it encodes
 * instruction words and runs one transfer at a time.
 * Assumes pready is sampled at rising pclk edges.
 */
`timescale 1ns/1ps
module mlo_apb_master (
    // Clock
    input  wire logic        pclk,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    // APB answer
    input  wire logic        pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    // Don't-care opcode bits go out as zero for codes 0 to 7; unknown codes 8 to 15 carry d and f
    function automatic logic [31:0] enc(input logic [3:0] op, input logic d,
                                        input logic [6:0] f, input logic [7:0] k);
        if (op == 4'h1 || op == 4'h2)
            return {18'h0, op, 2'h0, k};
        if (op == 4'h4)
            return {18'h0, op, 3'h0, f};
        if (op == 4'h0 || op == 4'h6)
            return {18'h0, op, 10'h0};
        return {18'h0, op, 2'h0, d, f};
    endfunction : enc

    // Leading edge wait keeps two transfers from assigning psel in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // The first edge that samples pready high ends this wait; if pready never rises, only the bench timeout ends it
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : mlo_apb_master

//--- tb/mcu_literal_move_logic_ops_tb.sv
/*
 * Self-checking bench of the execution unit: a reference model of
 * accumulator, flags, pc and file registers predicts the reads of those registers; stack pointer reads use fixed values.
 * Assumes the register map and encoding of mlo_pkg.
 */
`timescale 1ns/1ps
module mcu_literal_move_logic_ops_tb;
    typedef struct packed {logic rd; logic err; logic [31:0] d;} mlo_note_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, global_irq_enable;
    logic [7:0]  paddr, m_acc, m_f [128], a, fv, k, r;
    logic [31:0] pwdata, prdata, v;
    logic [3:0]  pstrb, o;
    logic [12:0] m_pc, s0, s1;
    logic [6:0]  f;
    logic        m_z, m_c, m_gie, m_ill, d;
    mlo_note_s   q [$];
    int          fail_count, check_count, cycles;
    integer      seed = 32'h3E8D15CF;

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    mlo_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable));
    mlo_apb_master u_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));

    // ----------------------------------------
    // Compare, report, finish
    // ----------------------------------------
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e || $isunknown(g)) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Oldest note is judged at each completed access phase
    always @(posedge pclk) begin
        mlo_note_s n;
        if (psel && penable && pready === 1'b1) begin
            n = q.pop_front();
            chk_bit("pslverr", n.err, pslverr);
            if (n.rd)
                chk_word("prdata", n.d, prdata);
        end
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] s,
                       input logic [31:0] e, input logic err);
        q.push_back('{rd: !w, err: err, d: e});
        u_mst.xfer(w, ad, wd, s);
    endtask : bus

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        bus(1'b1, ad, wd, 4'hF, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0, 4'h0, e, 1'b0);
    endtask : rd

    task automatic chk_state(input logic [6:0] fa);
        rd(mlo_pkg::ADDR_ACC, {24'h0, m_acc});
        rd(mlo_pkg::ADDR_STATUS, {28'h0, m_ill, m_gie, m_c, m_z});
        rd(mlo_pkg::ADDR_PC, {19'h0, m_pc});
        wr(mlo_pkg::ADDR_FADDR, {25'h0, fa});
        rd(mlo_pkg::ADDR_FDATA, {24'h0, m_f[fa]});
    endtask : chk_state

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        {m_acc, m_z, m_c, m_gie, m_ill, m_pc} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(mlo_pkg::ADDR_ACC, 32'h0);
        rd(mlo_pkg::ADDR_STATUS, 32'h0);
        rd(mlo_pkg::ADDR_PC, 32'h0);
        rd(mlo_pkg::ADDR_FADDR, 32'h0);
        rd(mlo_pkg::ADDR_STACK, 32'h0);
        // File contents are undefined after reset: give entry 0 a value
        m_f[0] = 8'hC3;
        wr(mlo_pkg::ADDR_FDATA, 32'h0000_00C3);
        rd(mlo_pkg::ADDR_FDATA, 32'h0000_00C3);
        chk_bit("global_irq_enable", 1'b0, global_irq_enable);
        // Refused accesses leave the state alone
        bus(1'b0, 8'h1C, 32'h0, 4'h0, 32'h0, 1'b1);
        bus(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
        rd(mlo_pkg::ADDR_INSTR, 32'h0);
        wr(mlo_pkg::ADDR_PC, 32'h0000_1234);
        bus(1'b1, mlo_pkg::ADDR_INSTR, u_mst.enc(4'h2, 1'b0, 7'h0, 8'h5A), 4'h1, 32'h0, 1'b0);
        chk_state(7'h00);
        v = $random(seed);
        s0 = v[12:0];
        v = $random(seed);
        s1 = v[12:0];
        wr(mlo_pkg::ADDR_STACK, {19'h0, s0});
        wr(mlo_pkg::ADDR_STACK, {19'h0, s1});
        rd(mlo_pkg::ADDR_STACK, 32'h2);
        for (int j = 0; j < 2; j++) begin
            wr(mlo_pkg::ADDR_INSTR, u_mst.enc(4'h6, 1'b0, 7'h0, 8'h0));
            m_pc = (j == 0) ? s1 : s0;
            m_gie = 1'b1;
            chk_state(7'h00);
            rd(mlo_pkg::ADDR_STACK, 32'h1 - j);
            chk_bit("global_irq_enable", 1'b1, global_irq_enable);
        end
        // A full stack refuses the ninth push
        for (int j = 0; j < 9; j++)
            wr(mlo_pkg::ADDR_STACK, 32'h0000_0ABC);
        rd(mlo_pkg::ADDR_STACK, 32'h8);
        wr(mlo_pkg::ADDR_INSTR, u_mst.enc(4'h6, 1'b0, 7'h0, 8'h0));
        m_pc = 13'h0ABC;
        rd(mlo_pkg::ADDR_PC, {19'h0, m_pc});
        rd(mlo_pkg::ADDR_STACK, 32'h7);
        // Every opcode but 6 (sent as 0) first, then random ones; each fourth pass uses zero operands
        for (int i = 0; i < 64; i++) begin
            v = $random(seed);
            o = (i < 16) ? i[3:0] : v[3:0];
            if (o == 4'h6)
                o = 4'h0;
            v = $random(seed);
            a = (i % 4 == 0) ? 8'h00 : v[7:0];
            fv = (i % 4 == 0) ? 8'h00 : v[15:8];
            k = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'hFF : v[23:16];
            f = v[30:24];
            d = v[31];
            v = $random(seed);
            {m_acc, m_gie, m_c, m_z, m_ill} = {a, v[2:0], 1'b0};
            m_f[f] = fv;
            wr(mlo_pkg::ADDR_ACC, {24'h0, a});
            wr(mlo_pkg::ADDR_STATUS, {28'h0, 1'b1, v[2:0]});
            wr(mlo_pkg::ADDR_FADDR, {25'h0, f});
            wr(mlo_pkg::ADDR_FDATA, {24'h0, fv});
            case (o)
                4'h1: r = m_acc | k;
                4'h2: r = k;
                4'h3: r = m_acc | fv;
                4'h5: r = fv;
                4'h7: r = {fv[6:0], m_c};
                default: r = m_acc;
            endcase
            if (o == 4'h1 || o == 4'h3 || o == 4'h5)
                m_z = (r == 8'h00);
            if (o == 4'h7)
                m_c = fv[7];
            if (o == 4'h4 || (d && o inside {4'h3, 4'h5, 4'h7}))
                m_f[f] = r;
            else if (o inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h7})
                m_acc = r;
            if (o > 4'h7)
                m_ill = 1'b1;
            m_pc = m_pc + 13'h0001;
            wr(mlo_pkg::ADDR_INSTR, u_mst.enc(o, d, f, k));
            chk_state(f);
            chk_bit("global_irq_enable", m_gie, global_irq_enable);
        end
        // Let the last note be judged before the verdict
        @(posedge pclk);
        chk_word("notes_left", 32'h0, q.size());
        tally_and_finish();
    end
endmodule : mcu_literal_move_logic_ops_tb
